// ### rtl/lfk_defs.svh
// register offsets, reset values and field positions of the indicator and
// key block; assumes an 8-bit byte address on the register bus
`ifndef LFK_DEFS_SVH
`define LFK_DEFS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define LFK_OFF_CTRL        8'h00
`define LFK_OFF_LED_LATCH   8'h04
`define LFK_OFF_TRI_LATCH   8'h08
`define LFK_OFF_KLED_LATCH  8'h0c
`define LFK_OFF_KEY_ENABLE  8'h10
`define LFK_OFF_KEY_MODE    8'h14
`define LFK_OFF_KEY_PULSE   8'h18
`define LFK_OFF_KEY_STATE   8'h1c
`define LFK_OFF_LED_STATE   8'h20

// ==========================================================================
// control register fields (write one to pulse)
`define LFK_CTRL_LED_RESET  0
`define LFK_CTRL_KEY_RESET  1

// ==========================================================================
// led state register field positions
`define LFK_LS_SINGLE_LSB   0
`define LFK_LS_TRI_GRN_LSB  8
`define LFK_LS_TRI_RED_LSB  16

// ==========================================================================
// reset values
`define LFK_RST_LATCH       32'h0000_0000
`define LFK_RST_KEY_ENABLE  32'hffff_ffff
`define LFK_RST_KEY_MODE    32'h0000_0000
`define LFK_RST_KEY_PULSE   32'h0000_0000

`endif

// ### rtl/lfk_pkg.sv
// types shared by the indicator and key block
// no surroundings assumed
package lfk_pkg;

  // ========================================================================
  // bus response codes
  typedef enum logic [1:0]
  {
    LFK_RESP_OKAY   = 2'h0,
    LFK_RESP_SLVERR = 2'h2
  } lfk_resp_t;

  // ========================================================================
  // one bus data word
  typedef logic [31:0] lfk_word_t;

endpackage

// ### rtl/lfk_led_cond.sv
// indicator conditioner: follows or latches one or two colour drives
// assumes drives come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none

module lfk_led_cond
#(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] drive_i,
  input  wire logic         latch_i,
  input  wire logic         clear_i,
  output logic      [W-1:0] lit_o
);
  import lfk_pkg::*;

  typedef struct packed
  {
    logic [W-1:0] held;
    logic [W-1:0] lit;
  } lfk_cond_st_t;

  lfk_cond_st_t st;
  lfk_cond_st_t next_st;

  // ========================================================================
  // latch holds every colour seen until cleared; a drive on the clear
  // cycle survives; both colours lit shows amber
  always_comb
  begin
    next_st = st;
    if (latch_i)
    begin
      next_st.held = (st.held & ~{W{clear_i}}) | drive_i; // RULE_04
      next_st.lit  = next_st.held;                       // RULE_03
    end
    else
    begin
      next_st.held = '0;
      next_st.lit  = drive_i;                            // RULE_04
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign lit_o = st.lit;

endmodule
`default_nettype wire

// ### rtl/lfk_key_cell.sv
// one operator key: normal or toggled output, lock and minimum pulse
// assumes press_i is already synchronised to clk_i
`timescale 1ns/10ps
`default_nettype none

module lfk_key_cell
#(
  parameter int TW = 16
)
(
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic          press_i,
  input  wire logic          enable_i,
  input  wire logic          toggle_i,
  input  wire logic          reset_i,
  input  wire logic          restore_i,
  input  wire logic          restore_val_i,
  input  wire logic [TW-1:0] pulse_len_i,
  output logic               out_o
);
  import lfk_pkg::*;

  typedef struct packed
  {
    logic          out;
    logic          prev;
    logic [TW-1:0] timer;
  } lfk_key_st_t;

  lfk_key_st_t st;
  lfk_key_st_t next_st;
  logic        press_edge;

  // ========================================================================
  // output behaviour per mode
  always_comb
  begin
    next_st      = st;
    next_st.prev = press_i;
    press_edge   = press_i & ~st.prev;                  // RULE_17
    if (toggle_i)
    begin
      next_st.timer = '0;
      if (restore_i)
        next_st.out = restore_val_i;                    // RULE_14
      else if (!enable_i)
        next_st.out = st.out;                           // RULE_09
      else if (press_edge)
        next_st.out = ~st.out;                          // RULE_17
      else if (reset_i)
        next_st.out = 1'b0;                             // RULE_11
    end
    else if (!enable_i)
    begin
      next_st.out   = 1'b0;                             // RULE_10
      next_st.timer = '0;
    end
    else
    begin
      if (press_edge)
        next_st.timer = pulse_len_i;                    // RULE_13
      else if (st.timer != '0)
        next_st.timer = st.timer - 1'b1;
      next_st.out = press_i | (next_st.timer != '0);    // RULE_12
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign out_o = st.out;

endmodule
`default_nettype wire

// ### rtl/lfk_top.sv
// indicator and operator key block with an axi4-lite register slave
// assumes key pins are asynchronous; drives come from same-clock logic;
// nonvolatile storage sits outside and answers on nv_word_i / nv_load_i
//
// How it works
// RULE_01: single indicator lit red from one signal
// RULE_02: tri indicator: green input green, red red
// RULE_03: both inputs asserted lights tri indicator amber
// RULE_04: per indicator choice: follow or latch till reset
// RULE_05: unfitted indicator positions have no effect
// RULE_06: key states as word, bit 0 key 1
// RULE_07: per-key enable setting gates key output
// RULE_08: per-key mode: toggled or normal momentary
// RULE_09: locked toggled key holds output, ignores presses
// RULE_10: locked normal key output forced inactive
// RULE_11: toggled output stays set until reset command
// RULE_12: normal output follows press, clears on release
// RULE_13: optional minimum pulse length in normal mode
// RULE_14: key states saved to and restored from nonvolatile; the restore reaches only keys in toggled mode
// RULE_15: each key has its own tri indicator
// RULE_16: unfitted key mappings produce no effect
// RULE_17: toggle inverts once per press rising edge
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lfk_defs.svh"

module lfk_top
#(
  parameter int N_LED   = 8,
  parameter int FIT_LED = 4,
  parameter int N_TRI   = 8,
  parameter int FIT_TRI = 8,
  parameter int N_KEY   = 10,
  parameter int FIT_KEY = 10,
  parameter int TW      = 16
)
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire lfk_pkg::lfk_word_t s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [7:0]        s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output lfk_pkg::lfk_word_t     s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // indicator drives and lamps
  input  wire logic [N_LED-1:0]  indicator_red_drive_drive_i,
  input  wire logic [N_TRI-1:0]  indicator_green_drive_i,
  input  wire logic [N_TRI-1:0]  indicator_red_drive_i,
  input  wire logic [N_KEY-1:0]  key_green_drive_i,
  input  wire logic [N_KEY-1:0]  key_red_drive_i,
  output logic      [N_LED-1:0]  indicator_red_drive_o,
  output logic      [N_TRI-1:0]  tri_green_o,
  output logic      [N_TRI-1:0]  tri_red_o,
  output logic      [N_KEY-1:0]  key_led_green_o,
  output logic      [N_KEY-1:0]  key_indicator_red_drive_o,
  // operator keys and scheme logic
  input  wire logic [N_KEY-1:0]  key_press_i,
  output logic      [N_KEY-1:0]  key_state_word_o,
  // nonvolatile key storage
  input  wire logic [N_KEY-1:0]  nv_word_i,
  input  wire logic              nv_load_i,
  output logic      [N_KEY-1:0]  nv_word_o,
  output logic                   nv_save_o
);
  import lfk_pkg::*;

  typedef struct packed
  {
    logic             aw_got;
    logic [7:0]       awaddr;
    logic             w_got;
    lfk_word_t        wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    lfk_resp_t        bresp;
    logic             rvalid;
    lfk_word_t        rdata;
    lfk_resp_t        rresp;
    lfk_word_t        led_latch;
    lfk_word_t        tri_latch;
    lfk_word_t        kled_latch;
    lfk_word_t        key_enable;
    lfk_word_t        key_mode;
    lfk_word_t        key_pulse;
    logic             led_clear;
    logic             key_reset;
    logic [N_KEY-1:0] press_s1;
    logic [N_KEY-1:0] press_s2;
    logic [N_KEY-1:0] saved_word;
    logic             save;
  } lfk_top_st_t;

  lfk_top_st_t      st;
  lfk_top_st_t      next_st;
  logic [N_KEY-1:0] key_out;
  logic [N_LED-1:0] led_lit;
  logic [N_TRI-1:0] tri_g;
  logic [N_TRI-1:0] tri_r;
  lfk_word_t        led_state_word;

  // ========================================================================
  // byte-lane merge for register writes
  function automatic lfk_word_t lfk_merge(input lfk_word_t old_v,
                                          input lfk_word_t new_v,
                                          input logic [3:0] strb);
    lfk_word_t r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // ========================================================================
  // led state word for readback
  always_comb
  begin
    led_state_word = '0;
    led_state_word[`LFK_LS_SINGLE_LSB +: N_LED]  = led_lit;
    led_state_word[`LFK_LS_TRI_GRN_LSB +: N_TRI] = tri_g;
    led_state_word[`LFK_LS_TRI_RED_LSB +: N_TRI] = tri_r;
  end

  // ========================================================================
  // bus handshakes, register file, key synchronisers and save detect
  always_comb
  begin
    next_st           = st;
    next_st.led_clear = 1'b0;
    next_st.key_reset = 1'b0;
    next_st.press_s1  = key_press_i;
    next_st.press_s2  = st.press_s1;
    next_st.saved_word = key_out;
    next_st.save      = (key_out != st.saved_word);     // RULE_14
    // write address and data are taken independently
    if (s_axi_awvalid_i && !st.aw_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st.w_got && !st.bvalid)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata_i;
      next_st.wstrb = s_axi_wstrb_i;
    end
    if (st.bvalid && s_axi_bready_i)
      next_st.bvalid = 1'b0;
    // both halves held: perform the write and answer
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = LFK_RESP_OKAY;
      case ({st.awaddr[7:2], 2'h0})
        `LFK_OFF_CTRL:
        begin
          if (st.wstrb[0])
          begin
            next_st.led_clear = st.wdata[`LFK_CTRL_LED_RESET];
            next_st.key_reset = st.wdata[`LFK_CTRL_KEY_RESET];
          end
        end
        `LFK_OFF_LED_LATCH:
          next_st.led_latch  = lfk_merge(st.led_latch, st.wdata, st.wstrb);
        `LFK_OFF_TRI_LATCH:
          next_st.tri_latch  = lfk_merge(st.tri_latch, st.wdata, st.wstrb);
        `LFK_OFF_KLED_LATCH:
          next_st.kled_latch = lfk_merge(st.kled_latch, st.wdata,
                                         st.wstrb);
        `LFK_OFF_KEY_ENABLE:
          next_st.key_enable = lfk_merge(st.key_enable, st.wdata,
                                         st.wstrb);     // RULE_07
        `LFK_OFF_KEY_MODE:
          next_st.key_mode   = lfk_merge(st.key_mode, st.wdata,
                                         st.wstrb);     // RULE_08
        `LFK_OFF_KEY_PULSE:
          next_st.key_pulse  = lfk_merge(st.key_pulse, st.wdata, st.wstrb);
        `LFK_OFF_KEY_STATE,
        `LFK_OFF_LED_STATE:
          next_st.bresp = LFK_RESP_OKAY;                // read-only, dropped
        default:
          next_st.bresp = LFK_RESP_SLVERR;
      endcase
    end
    // read channel: answer on the edge that takes the address
    if (st.rvalid && s_axi_rready_i)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid_i && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = LFK_RESP_OKAY;
      next_st.rdata  = '0;
      case ({s_axi_araddr_i[7:2], 2'h0})
        `LFK_OFF_CTRL:
          next_st.rdata = '0;
        `LFK_OFF_LED_LATCH:
          next_st.rdata[N_LED-1:0] = st.led_latch[N_LED-1:0];
        `LFK_OFF_TRI_LATCH:
          next_st.rdata[N_TRI-1:0] = st.tri_latch[N_TRI-1:0];
        `LFK_OFF_KLED_LATCH:
          next_st.rdata[N_KEY-1:0] = st.kled_latch[N_KEY-1:0];
        `LFK_OFF_KEY_ENABLE:
          next_st.rdata[N_KEY-1:0] = st.key_enable[N_KEY-1:0];
        `LFK_OFF_KEY_MODE:
          next_st.rdata[N_KEY-1:0] = st.key_mode[N_KEY-1:0];
        `LFK_OFF_KEY_PULSE:
          next_st.rdata[TW-1:0] = st.key_pulse[TW-1:0];
        `LFK_OFF_KEY_STATE:
          next_st.rdata[N_KEY-1:0] = key_out;           // RULE_06
        `LFK_OFF_LED_STATE:
          next_st.rdata = led_state_word;
        default:
          next_st.rresp = LFK_RESP_SLVERR;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st            <= '0;
      st.key_enable <= `LFK_RST_KEY_ENABLE;
      st.key_mode   <= `LFK_RST_KEY_MODE;
      st.key_pulse  <= `LFK_RST_KEY_PULSE;
      st.led_latch  <= `LFK_RST_LATCH;
      st.tri_latch  <= `LFK_RST_LATCH;
      st.kled_latch <= `LFK_RST_LATCH;
    end
    else
      st <= next_st;
  end

  // ========================================================================
  // single-colour indicators, only fitted positions are built
  for (genvar i = 0; i < N_LED; i++)
  begin : g_led
    if (i < FIT_LED)
    begin : g_fit
      lfk_led_cond #(.W(1)) u_cond
      (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .drive_i (indicator_red_drive_drive_i[i]),                 // RULE_01
        .latch_i (st.led_latch[i]),
        .clear_i (st.led_clear),
        .lit_o   (led_lit[i])
      );
    end
    else
    begin : g_nofit
      assign led_lit[i] = 1'b0;                        // RULE_05
    end
  end

  // ========================================================================
  // tri-colour indicators: green and red conditioned together
  for (genvar i = 0; i < N_TRI; i++)
  begin : g_tri
    if (i < FIT_TRI)
    begin : g_fit
      lfk_led_cond #(.W(2)) u_cond
      (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .drive_i ({indicator_red_drive_i[i],
                   indicator_green_drive_i[i]}),       // RULE_02
        .latch_i (st.tri_latch[i]),
        .clear_i (st.led_clear),
        .lit_o   ({tri_r[i], tri_g[i]})
      );
    end
    else
    begin : g_nofit
      assign tri_r[i] = 1'b0;                          // RULE_05
      assign tri_g[i] = 1'b0;
    end
  end

  // ========================================================================
  // keys, each with its own tri-colour indicator
  for (genvar i = 0; i < N_KEY; i++)
  begin : g_key
    if (i < FIT_KEY)
    begin : g_fit
      lfk_key_cell #(.TW(TW)) u_key
      (
        .clk_i         (clk_i),
        .srst_i        (srst_i),
        .press_i       (st.press_s2[i]),
        .enable_i      (st.key_enable[i]),
        .toggle_i      (st.key_mode[i]),
        .reset_i       (st.key_reset),
        .restore_i     (nv_load_i),
        .restore_val_i (nv_word_i[i]),
        .pulse_len_i   (st.key_pulse[TW-1:0]),
        .out_o         (key_out[i])
      );
      lfk_led_cond #(.W(2)) u_kled
      (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .drive_i ({key_red_drive_i[i], key_green_drive_i[i]}), // RULE_15
        .latch_i (st.kled_latch[i]),
        .clear_i (st.led_clear),
        .lit_o   ({key_indicator_red_drive_o[i], key_led_green_o[i]})
      );
    end
    else
    begin : g_nofit
      assign key_out[i]         = 1'b0;                // RULE_16
      assign key_indicator_red_drive_o[i]   = 1'b0;
      assign key_led_green_o[i] = 1'b0;
    end
  end

  // ========================================================================
  // outputs
  assign s_axi_awready_o  = ~st.aw_got & ~st.bvalid;
  assign s_axi_wready_o   = ~st.w_got & ~st.bvalid;
  assign s_axi_bvalid_o   = st.bvalid;
  assign s_axi_bresp_o    = st.bresp;
  assign s_axi_arready_o  = ~st.rvalid;
  assign s_axi_rvalid_o   = st.rvalid;
  assign s_axi_rdata_o    = st.rdata;
  assign s_axi_rresp_o    = st.rresp;
  assign indicator_red_drive_o        = led_lit;
  assign tri_green_o      = tri_g;
  assign tri_red_o        = tri_r;
  assign key_state_word_o = key_out;                    // RULE_06
  assign nv_word_o        = st.saved_word;
  assign nv_save_o        = st.save;                    // RULE_14

endmodule
`default_nettype wire

// ### tb/lfk_panel_model.sv
// operator panel model: presses one key pin for a set number of cycles
// assumes the bench pulses go_i for one cycle, changed after a rising edge
`timescale 1ns/10ps
`default_nettype none

module lfk_panel_model
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] idx_i,
  input  wire logic [7:0] len_i,
  output logic      [9:0] pins_o
);
  logic [7:0] cnt;

  // ==========================================================================
  // key press timing
  // pin held for len_i cycles (one cycle when len_i is 0), then released to 0 (pins are pulled down)
  always_ff @(posedge clk_i)
  begin
    if (srst_i || (!go_i && cnt <= 8'h01))
    begin
      pins_o <= '0;
      cnt    <= '0;
    end
    else if (go_i)
    begin
      pins_o <= 10'h001 << idx_i;
      cnt    <= len_i;
    end
    else
      cnt <= cnt - 8'h01;
  end
endmodule
`default_nettype wire

// ### tb/lfk_top_sva.sv
// checker for the indicator and key block, bound to the top module
// assumes one clock domain with synchronous active high reset
`timescale 1ns/10ps
`default_nettype none

module lfk_top_sva
#(
  parameter int N_LED   = 8,
  parameter int FIT_LED = 4,
  parameter int N_TRI   = 8,
  parameter int N_KEY   = 10
)
(
  input wire logic             clk_i,
  input wire logic             srst_i,
  input wire logic             s_axi_awvalid_i,
  input wire logic             s_axi_awready_o,
  input wire logic             s_axi_wvalid_i,
  input wire logic             s_axi_wready_o,
  input wire logic             s_axi_bvalid_o,
  input wire logic             s_axi_arvalid_i,
  input wire logic             s_axi_arready_o,
  input wire logic             s_axi_rvalid_o,
  input wire logic [N_LED-1:0] indicator_red_drive_drive_i,
  input wire logic [N_TRI-1:0] indicator_green_drive_i,
  input wire logic [N_TRI-1:0] indicator_red_drive_i,
  input wire logic [N_KEY-1:0] key_green_drive_i,
  input wire logic [N_LED-1:0] indicator_red_drive_o,
  input wire logic [N_TRI-1:0] tri_green_o,
  input wire logic [N_TRI-1:0] tri_red_o,
  input wire logic [N_KEY-1:0] key_led_green_o,
  input wire logic [N_KEY-1:0] key_state_word_o,
  input wire logic [N_KEY-1:0] nv_word_o
);
  localparam logic [N_LED-1:0] LED_FIT = N_LED'((64'h1 << FIT_LED) - 64'h1);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // ==========================================================================
  // lamps: a driven fitted lamp is lit next cycle in follow and latch modes alike
  a_unfit_dark: assert property ((indicator_red_drive_o & ~LED_FIT) == '0)
    else $error("unfitted lamp lit");
  a_led_lit: assert property (1'b1 |=> (indicator_red_drive_o & $past(indicator_red_drive_drive_i)
    & LED_FIT) == ($past(indicator_red_drive_drive_i) & LED_FIT))
    else $error("single lamp not lit by its drive");
  a_tri_green: assert property (1'b1 |=> (tri_green_o
    & $past(indicator_green_drive_i)) == $past(indicator_green_drive_i))
    else $error("tri lamp green missing");
  a_tri_amber: assert property (indicator_green_drive_i[0]
    && indicator_red_drive_i[0] |=> tri_green_o[0] && tri_red_o[0])
    else $error("tri lamp not amber");
  a_key_lamp: assert property (1'b1 |=> (key_led_green_o
    & $past(key_green_drive_i)) == $past(key_green_drive_i))
    else $error("key lamp not lit");

  // ==========================================================================
  // key word copy for nonvolatile storage, one cycle behind
  a_nv_copy: assert property (1'b1 |=> nv_word_o == $past(key_state_word_o))
    else $error("stored key word stale");

  // ==========================================================================
  // register bus handshakes
  a_wr_answer: assert property (s_axi_awvalid_i && s_axi_awready_o
    && s_axi_wvalid_i && s_axi_wready_o |=> ##1 s_axi_bvalid_o)
    else $error("write answer late");
  a_wr_refuse: assert property (s_axi_bvalid_o
    |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer late");
endmodule

bind lfk_top lfk_top_sva #(.N_LED(N_LED), .FIT_LED(FIT_LED), .N_TRI(N_TRI),
  .N_KEY(N_KEY)) u_sva (.*);
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the indicator and key block
// assumes default design parameters: 4 of 8 single lamps fitted, 10 keys
`timescale 1ns/10ps
`default_nettype none
`include "lfk_defs.svh"

module tb;
  import lfk_pkg::*;
  logic       clk_i, srst_i, awvalid, awready, wvalid, wready, bvalid;
  logic       arvalid, arready, rvalid, nv_load, nv_save, go;
  logic [7:0] awaddr, araddr, led_drv, led_o, trg_drv, trr_drv, trg, trr;
  logic [7:0] len;
  logic [3:0] idx;
  logic [1:0] bresp, rresp;
  logic [9:0] kg_drv, kr_drv, kg, kr, pins, kw, nv_in, nv_out;
  lfk_word_t  wdata, rdata, rd;
  int         bad_count, checks_done;

  // ==========================================================================
  // design, panel model and clock
  lfk_top dut (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .indicator_red_drive_drive_i(led_drv),
    .indicator_green_drive_i(trg_drv), .indicator_red_drive_i(trr_drv),
    .key_green_drive_i(kg_drv), .key_red_drive_i(kr_drv),
    .indicator_red_drive_o(led_o), .tri_green_o(trg), .tri_red_o(trr),
    .key_led_green_o(kg), .key_indicator_red_drive_o(kr), .key_press_i(pins),
    .key_state_word_o(kw), .nv_word_i(nv_in), .nv_load_i(nv_load),
    .nv_word_o(nv_out), .nv_save_o(nv_save));
  lfk_panel_model u_panel (.clk_i(clk_i), .srst_i(srst_i), .go_i(go),
    .idx_i(idx), .len_i(len), .pins_o(pins));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================================
  // report, compare and wait helpers
  task automatic summarize();
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    bad_count++;
    $display("FAIL %0t wait ran out", $time);
    summarize();
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // bus write: halves offered together
  task automatic wr(input logic [7:0] a, input lfk_word_t d,
                    input logic [1:0] er);
    int n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (n > 40)
        give_up();
    end
    while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    int n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (n > 40)
        give_up();
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    chk(32'(rresp), 32'(er));
  endtask

  task automatic press(input logic [3:0] k, input logic [7:0] l);
    idx <= k;
    len <= l;
    go  <= 1'b1;
    @(posedge clk_i);
    go  <= 1'b0;
  endtask

  task automatic wait_kw(input logic [9:0] m, input logic [9:0] v);
    int n = 0;
    while ((kw & m) !== v)
    begin
      @(posedge clk_i);
      n++;
      if (n > 12)
        give_up();
    end
    chk(32'(kw & m), 32'(v));
  endtask

  task automatic count_hi(input int k, input int span, input int exp);
    int c = 0;
    repeat (span)
    begin
      @(posedge clk_i);
      if (kw[k] === 1'b1)
        c++;
    end
    chk(32'(c), 32'(exp));
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_bus();
    rdr(8'h24, LFK_RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    wr(8'h24, 32'hffff_ffff, LFK_RESP_SLVERR);
    wr(`LFK_OFF_KEY_STATE, 32'h0000_03ff, LFK_RESP_OKAY);
    chk(32'(kw), 32'h0);
  endtask

  task automatic t_lamps();
    {led_drv, trg_drv, trr_drv} <= {8'hff, 8'h0f, 8'h3c};
    {kg_drv, kr_drv} <= {10'h155, 10'h0f0};
    ticks(2);
    chk(32'(led_o), 32'h0f);
    chk(32'({trg, trr}), 32'h0f3c);
    chk(32'({kg, kr}), 32'h554f0);
    {led_drv, trg_drv, trr_drv, kg_drv, kr_drv} <= '0;
    ticks(2);
    chk(32'({led_o, trg, trr}), 32'h0);
    chk(32'({kg, kr}), 32'h0);
  endtask

  task automatic t_latch();
    wr(`LFK_OFF_LED_LATCH, 32'h1, LFK_RESP_OKAY);
    led_drv <= 8'h03;
    @(posedge clk_i);
    led_drv <= 8'h00;
    ticks(4);
    chk(32'(led_o), 32'h01);
    wr(`LFK_OFF_CTRL, 32'h1, LFK_RESP_OKAY);
    ticks(2);
    chk(32'(led_o), 32'h00);
  endtask

  task automatic t_normal();
    press(4'd0, 8'd6);
    wait_kw(10'h001, 10'h001);
    wait_kw(10'h001, 10'h000);
    wr(`LFK_OFF_KEY_PULSE, 32'd5, LFK_RESP_OKAY);
    press(4'd0, 8'd1);
    count_hi(0, 20, 5);
    wr(`LFK_OFF_KEY_PULSE, 32'd0, LFK_RESP_OKAY);
    wr(`LFK_OFF_KEY_ENABLE, 32'h3fe, LFK_RESP_OKAY);
    press(4'd0, 8'd6);
    count_hi(0, 12, 0);
    wr(`LFK_OFF_KEY_ENABLE, 32'h3ff, LFK_RESP_OKAY);
  endtask

  task automatic t_toggle();
    wr(`LFK_OFF_KEY_MODE, 32'h2, LFK_RESP_OKAY);
    press(4'd1, 8'd8);
    wait_kw(10'h002, 10'h002);
    count_hi(1, 10, 10);
    rdr(`LFK_OFF_KEY_STATE, LFK_RESP_OKAY);
    chk(rd, 32'h2);
    press(4'd1, 8'd2);
    wait_kw(10'h002, 10'h000);
    press(4'd1, 8'd2);
    wait_kw(10'h002, 10'h002);
    wr(`LFK_OFF_KEY_ENABLE, 32'h3fd, LFK_RESP_OKAY);
    press(4'd1, 8'd2);
    count_hi(1, 8, 8);
    wr(`LFK_OFF_KEY_ENABLE, 32'h3ff, LFK_RESP_OKAY);
    wr(`LFK_OFF_CTRL, 32'h2, LFK_RESP_OKAY);
    wait_kw(10'h002, 10'h000);
  endtask

  task automatic t_restore();
    nv_in   <= 10'h002;
    nv_load <= 1'b1;
    @(posedge clk_i);
    nv_load <= 1'b0;
    wait_kw(10'h3ff, 10'h002);
    @(posedge clk_i);
    chk(32'(nv_save), 32'h1);
    chk(32'(nv_out), 32'h2);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    {srst_i, awvalid, wvalid, arvalid, nv_load, go} = 6'b100000;
    {awaddr, araddr, led_drv, trg_drv, trr_drv, len, idx} = '0;
    {kg_drv, kr_drv, nv_in, wdata} = '0;
    bad_count   = 0;
    checks_done = 0;
    ticks(8);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_bus();
    t_lamps();
    t_latch();
    t_normal();
    t_toggle();
    t_restore();
    summarize();
  end
endmodule
`default_nettype wire
